// ==== hw/rdms_top.sv ====
// run/debug mode sequencer with forced save/return address generator
// ==========================================================
`timescale 1ns/100ps

module rdms_top
	import rdms_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// processor card
	input  wire logic        address_strobe_n_i,
	input  wire logic        processor_bus_request_i,
	input  wire logic        halt_flag_bit_i,
	input  wire logic        init_n_i,
	input  wire logic [15:0] cpu_addr_i,
	// front panel and external debug
	input  wire logic        halt_button_i,
	input  wire logic        user_debug_n_i,
	input  wire logic        step_mode_i,
	input  wire logic        halt_instruction_selector_i,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// sequencer outputs
	output logic      [15:0] addr_o,
	output logic             cpu_addr_drive_enable_o,
	output logic             debug_addr_enable_o,
	output logic             halt_request_o,
	output logic             monitor_active_n_o
);

	// ==========================================================
	// address table
	function automatic logic [TBL_W-1:0] tbl_entry(input logic [4:0] idx);
		logic [TBL_W-1:0] y;
		y = 8'h00;
		case (idx)
			5'd1, 5'd2, 5'd7, 5'd8, 5'd13, 5'd14,
			5'd17, 5'd18:                  y = 8'h30;
			5'd3:                          y = 8'h0d;
			5'd4, 5'd10, 5'd23, 5'd26, 5'd29: y = 8'h31;
			5'd5:                          y = 8'h32;
			5'd6, 5'd25:                   y = 8'h33;
			5'd9, 5'd24:                   y = 8'h0c;
			5'd11:                         y = 8'h34;
			5'd12, 5'd28:                  y = 8'h35;
			5'd31, 5'd27:                  y = 8'h0b;
			5'd16:                         y = 8'h36;
			5'd19:                         y = 8'h0f;
			5'd20:                         y = 8'h78;
			5'd21:                         y = 8'h38;
			5'd22:                         y = 8'h37;
			5'd30:                         y = 8'hcd;
			default:                       y = 8'h00;
		endcase
		return y;
	endfunction

	// the counter's terminal count shows index 31 in place of 15
	function automatic logic [4:0] tbl_index(input logic ext,
		input logic [3:0] cnt);
		if (!ext && cnt == CNT_TC) begin
			return TBL_TC_INDEX;
		end
		return {ext, cnt};
	endfunction

	function automatic logic [15:0] tbl_addr(input logic [TBL_W-1:0] y);
		if (y[TBL_HIGH_BIT]) begin
			return {ADDR_PAGE_HI, y[3:0]};
		end
		return {ADDR_PAGE_LO, y[3:0]};
	endfunction

	// ==========================================================
	// state
	rdms_state_s st;
	rdms_state_s next_st;

	logic             as_rise;
	logic             br_rise;
	logic             br_fall;
	logic             halt_en;
	logic             halt_req;
	logic             detect_en;
	logic [TBL_W-1:0] entry;
	logic             bus_req;
	logic             ack;

	always_comb begin
		// edges only from the second and third stages
		as_rise   = st.syn2[SYN_AS_N] & ~st.syn3[SYN_AS_N];
		br_rise   = st.syn2[SYN_BR] & ~st.syn3[SYN_BR];
		br_fall   = ~st.syn2[SYN_BR] & st.syn3[SYN_BR];
		halt_en   = st.hold | st.syn2[SYN_STEP]
			| ~st.syn2[SYN_UDN] | st.sw_halt;
		halt_req  = ~st.mode_ff | ~st.hlatch_n;
		detect_en = ~st.mon_n | st.syn2[SYN_SEL];
		entry     = tbl_entry(tbl_index(st.ext, st.cnt));
		bus_req   = avs_read_i | avs_write_i;
		ack       = bus_req && st.bus == RDMS_BUS_ACK;
	end

	always_comb begin
		next_st = st;
		next_st.syn1 = {address_strobe_n_i, processor_bus_request_i,
			halt_flag_bit_i, halt_button_i, user_debug_n_i,
			step_mode_i, halt_instruction_selector_i};
		next_st.syn2 = st.syn1;
		next_st.syn3 = st.syn2;

		// pushbutton latch: a held button keeps the request alive
		if (st.syn2[SYN_BTN]) begin
			next_st.hold = 1'b1;
		end else if (st.dae) begin
			next_st.hold = 1'b0;
		end

		// mode flop: the monitor-active status gates the enable
		if (as_rise) begin
			next_st.mode_ff = ~(halt_en & st.mon_n);
		end

		// halt-instruction latch
		if (st.dae) begin
			next_st.hlatch_n = 1'b1;
		end else if (detect_en && st.syn2[SYN_HF]
			&& !st.syn2[SYN_AS_N]) begin
			next_st.hlatch_n = 1'b0;
		end

		// generator: enable, counter and extension latch
		if (!st.dae && br_rise && halt_req) begin
			next_st.dae = 1'b1;
			next_st.cnt = st.cnt + 4'h1;
			if (st.cnt == CNT_TC) begin
				next_st.ext = 1'b1;
			end
			if (st.cnt == CNT_RST && !st.ext) begin
				next_st.mon_n = 1'b0;
			end
		end else if (st.dae && br_rise
			&& !entry[TBL_LAST_BIT]) begin
			next_st.cnt = st.cnt + 4'h1;
			if (st.cnt == CNT_TC) begin
				next_st.ext = 1'b1;
			end
		end else if (st.dae && br_fall && entry[TBL_LAST_BIT]) begin
			next_st.dae = 1'b0;
			if (entry[TBL_RET_END_BIT]) begin
				next_st.cnt   = CNT_RST;
				next_st.ext   = EXT_RST;
				next_st.mon_n = 1'b1;
			end
		end

		// initialise: generator and monitor status latch back to start
		if (!init_n_i) begin
			next_st.cnt   = CNT_RST;
			next_st.ext   = EXT_RST;
			next_st.dae   = DAE_RST;
			next_st.mon_n = MON_N_RST;
		end

		// address buffers, registered
		if (st.dae && st.syn2[SYN_BR]) begin
			next_st.addr = tbl_addr(entry);
		end else if (st.dae) begin
			next_st.addr = st.addr;
		end else begin
			next_st.addr = cpu_addr_i;
		end

		// avalon slave: one wait cycle, then the answer
		next_st.bus = RDMS_BUS_IDLE;
		if (bus_req && st.bus == RDMS_BUS_IDLE) begin
			next_st.bus   = RDMS_BUS_ACK;
			next_st.rdata = RDATA_RST;
			if (avs_read_i && avs_address_i == REG_STATUS) begin
				next_st.rdata = {17'h0_0000, tbl_index(st.ext, st.cnt),
					st.cnt, st.ext, st.dae, halt_req, st.mon_n,
					st.mode_ff, st.hlatch_n};
			end else if (avs_read_i && avs_address_i == REG_CONTROL) begin
				next_st.rdata = {31'h0000_0000, st.sw_halt};
			end
		end
		if (ack && avs_write_i && avs_address_i == REG_CONTROL
			&& avs_byteenable_i[0]) begin
			next_st.sw_halt = avs_writedata_i[CTL_SW_HALT];
		end

		// outputs come from the next state, so each pin is a bare flop
		// and still shows the same cycle as the state it reports
		next_st.drv  = ~next_st.dae;
		next_st.halt = ~next_st.mode_ff | ~next_st.hlatch_n;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st.syn1     <= SYN_RST;
			st.syn2     <= SYN_RST;
			st.syn3     <= SYN_RST;
			st.mode_ff  <= MODE_RST;
			st.hlatch_n <= HLATCH_RST;
			st.hold     <= HOLD_RST;
			st.dae      <= DAE_RST;
			st.cnt      <= CNT_RST;
			st.ext      <= EXT_RST;
			st.mon_n    <= MON_N_RST;
			st.drv      <= DRV_RST;
			st.halt     <= HALT_RST;
			st.addr     <= ADDR_RST;
			st.sw_halt  <= SW_HALT_RST;
			st.bus      <= RDMS_BUS_IDLE;
			st.rdata    <= RDATA_RST;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs, all from state flops
	always_comb begin
		addr_o                  = st.addr;
		cpu_addr_drive_enable_o = st.drv;
		debug_addr_enable_o     = st.dae;
		halt_request_o          = st.halt;
		monitor_active_n_o      = st.mon_n;
		avs_readdata_o          = st.rdata;
		avs_waitrequest_o       = st.bus[0];
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_halt_gate_set: assert property (
		as_rise && !st.mon_n |=> st.mode_ff)
		else $error("halt enable acted while monitor active");

	a_halt_arm: assert property (
		as_rise && halt_en && st.mon_n |=> !st.mode_ff && halt_request_o)
		else $error("halt not armed on strobe edge");

	a_halt_ends: assert property (
		as_rise && !st.mon_n && st.hlatch_n |=> !halt_request_o)
		else $error("halt request not ended after monitor active");

	a_detect_hit: assert property (
		!st.dae && detect_en && st.syn2[SYN_HF] && !st.syn2[SYN_AS_N]
		|=> !st.hlatch_n)
		else $error("halt instruction missed");

	a_pulse_ignore: assert property (
		!st.dae && st.mon_n && !st.syn2[SYN_SEL] && st.hlatch_n
		|=> st.hlatch_n)
		else $error("user halt acted at pulse setting");

	a_latch_rearm: assert property (
		st.dae |=> st.hlatch_n)
		else $error("halt latch not set during sequence");

	a_save_end: assert property (
		st.dae && br_fall && entry[TBL_LAST_BIT] && init_n_i
		|=> !st.dae ##1 $stable(st.cnt))
		else $error("sequence did not stop on last entry");

	a_return_end: assert property (
		st.dae && br_fall && entry[TBL_RET_END_BIT] && init_n_i
		|=> st.cnt == CNT_RST && !st.ext && st.mon_n)
		else $error("counter not cleared after return");

	a_restart_step: assert property (
		!st.dae && br_rise && halt_req && init_n_i
		|=> st.dae && st.cnt == $past(st.cnt) + 4'h1)
		else $error("counter did not step on restart");

	a_cpu_addr_drive_enable_off: assert property (
		cpu_addr_drive_enable_o != debug_addr_enable_o)
		else $error("processor address drive wrong");

	a_pass_through: assert property (
		!st.dae ##1 !st.dae |-> addr_o == $past(cpu_addr_i))
		else $error("address not passed through");

	a_bus_answer: assert property (
		bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("slave did not answer in one cycle");

	a_power_halt: assert property (
		$rose(rst_n_i) |-> halt_request_o && st.hlatch_n
		&& !st.mode_ff && !monitor_active_n_o)
		else $error("power-on state wrong");

	a_enable_src: assert property (
		as_rise && st.mon_n && !st.syn2[SYN_UDN]
		|=> !st.mode_ff)
		else $error("user debug request not armed");

	a_hold_button: assert property (
		st.syn2[SYN_BTN] |=> st.hold)
		else $error("button request not latched");

	a_hold_release: assert property (
		st.hold && !st.syn2[SYN_BTN] && st.dae |=> !st.hold)
		else $error("button latch not cleared on release");

	a_step_rearm: assert property (
		as_rise && st.syn2[SYN_STEP] && st.mon_n |=> halt_request_o)
		else $error("step mode did not re-arm halt");

	a_debug_detect: assert property (
		!st.dae && st.mon_n && st.syn2[SYN_SEL] && st.syn2[SYN_HF]
		&& !st.syn2[SYN_AS_N] |=> halt_request_o)
		else $error("halt in run missed at debug setting");

	a_step_save: assert property (
		st.dae && br_rise && !entry[TBL_LAST_BIT] && init_n_i
		|=> st.cnt == $past(st.cnt) + 4'h1)
		else $error("counter did not step on bus request");

	a_tc_index: assert property (
		st.dae && br_rise && !st.ext && st.cnt == CNT_TC && init_n_i
		|=> st.ext && st.cnt == CNT_RST)
		else $error("extension latch not set at terminal count");

	a_mon_enter: assert property (
		!st.dae && br_rise && halt_req && init_n_i
		&& st.cnt == CNT_RST && !st.ext |=> !monitor_active_n_o)
		else $error("monitor status not entered");

	a_init_clear: assert property (
		!init_n_i |=> debug_addr_enable_o && !monitor_active_n_o
		&& st.cnt == CNT_RST && !st.ext)
		else $error("initialise did not clear the generator");

	a_bus_release: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("slave answer held longer than one cycle");

	c_save_done: cover property (
		st.dae && br_fall && entry == 8'h78);
	c_return_done: cover property (
		st.dae && br_fall && entry == 8'hcd);
	c_step_halt: cover property (
		st.syn2[SYN_STEP] && as_rise && st.mon_n);
	c_user_halt: cover property (
		!st.dae && st.mon_n && st.syn2[SYN_SEL] && !st.hlatch_n);

endmodule // rdms_top

// ==== hw/rdms_pkg.sv ====
// package of constants and types for the run/debug mode sequencer
package rdms_pkg;

	// ==========================================================
	// synchronised input vector, one bit per pin
	localparam int SYN_W    = 7;
	localparam int SYN_AS_N = 6;  // address_strobe_n
	localparam int SYN_BR   = 5;  // processor_bus_request
	localparam int SYN_HF   = 4;  // halt_flag_bit
	localparam int SYN_BTN  = 3;  // halt pushbutton
	localparam int SYN_UDN  = 2;  // user debug input, active low
	localparam int SYN_STEP = 1;  // run-mode switch at single step
	localparam int SYN_SEL  = 0;  // halt_instruction_selector, 1 = debug
	localparam logic [SYN_W-1:0] SYN_RST = 7'b100_0100;

	// ==========================================================
	// address table layout
	localparam int TBL_DEPTH       = 32;
	localparam int TBL_W           = 8;
	localparam int TBL_LAST_BIT    = 6;   // table_last_marker
	localparam int TBL_RET_END_BIT = 7;   // table_return_end_marker
	localparam int TBL_HIGH_BIT    = 5;   // selects the upper address page
	localparam logic [4:0]  TBL_TC_INDEX = 5'h1f;
	localparam logic [3:0]  CNT_TC       = 4'hf;
	localparam logic [11:0] ADDR_PAGE_HI = 12'h780;
	localparam logic [11:0] ADDR_PAGE_LO = 12'h77f;

	// ==========================================================
	// reset values of the sequencer
	localparam logic [3:0]  CNT_RST     = 4'h0;
	localparam logic        EXT_RST     = 1'b0;
	localparam logic        DAE_RST     = 1'b1;
	localparam logic        MODE_RST    = 1'b0;
	localparam logic        HLATCH_RST  = 1'b1;
	localparam logic        MON_N_RST   = 1'b0;
	localparam logic        DRV_RST     = 1'b0;
	localparam logic        HALT_RST    = 1'b1;
	localparam logic        HOLD_RST    = 1'b0;
	localparam logic        SW_HALT_RST = 1'b0;
	localparam logic [15:0] ADDR_RST    = 16'h0000;

	// ==========================================================
	// register map, byte addresses on the avalon slave
	localparam logic [3:0]  REG_STATUS  = 4'h0;
	localparam logic [3:0]  REG_CONTROL = 4'h4;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
	localparam int CTL_SW_HALT = 0;

	// ==========================================================
	// bus slave phase
	typedef enum logic [1:0] {
		RDMS_BUS_IDLE = 2'b01,
		RDMS_BUS_ACK  = 2'b10
	} rdms_bus_e;

	typedef struct packed {
		logic [SYN_W-1:0] syn1;
		logic [SYN_W-1:0] syn2;
		logic [SYN_W-1:0] syn3;
		logic             mode_ff;
		logic             hlatch_n;
		logic             hold;
		logic             dae;
		logic [3:0]       cnt;
		logic             ext;
		logic             mon_n;
		logic             drv;
		logic             halt;
		logic [15:0]      addr;
		logic             sw_halt;
		rdms_bus_e        bus;
		logic [31:0]      rdata;
	} rdms_state_s;

endpackage

// ==== verif/rdms_cpu_model.sv ====
// processor card model: address strobe, bus request, halt flag, address
`timescale 1ns/100ps

module rdms_cpu_model (
	input  wire logic        clk_i,
	output logic             address_strobe_n_o,
	output logic             processor_bus_request_o,
	output logic             halt_flag_bit_o,
	output logic      [15:0] cpu_addr_o
);
	initial begin
		address_strobe_n_o = 1'b1;
		processor_bus_request_o = 1'b0;
		halt_flag_bit_o = 1'b1;
		cpu_addr_o = 16'h0000;
	end

	// ==========================================================
	// bus cycles
	// the flag line is not driven outside the strobe, so it flips
	task automatic strobe(input logic flag);
		halt_flag_bit_o <= flag;
		address_strobe_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		address_strobe_n_o <= 1'b1;
		halt_flag_bit_o <= ~flag;
		repeat (8) @(posedge clk_i);
	endtask

	task automatic req_hi(input logic [15:0] a);
		cpu_addr_o <= a;
		processor_bus_request_o <= 1'b1;
	endtask

	// released address lines show a changed pattern, not the old value
	task automatic req_lo();
		processor_bus_request_o <= 1'b0;
		cpu_addr_o <= ~cpu_addr_o;
	endtask
endmodule // rdms_cpu_model

// ==== verif/testbench.sv ====
// self-checking bench for the run/debug mode sequencer
`timescale 1ns/100ps

module testbench;
	import rdms_pkg::*;
	typedef struct {int sel; logic [15:0] v;} rdms_note_s;
	localparam logic [15:0] SEQ [30] = '{
		16'h7800, 16'h7800, 16'h77fd, 16'h7801, 16'h7802, 16'h7803,
		16'h7800, 16'h7800, 16'h77fc, 16'h7801, 16'h7804, 16'h7805,
		16'h7800, 16'h7800, 16'h77fb, 16'h7806, 16'h7800, 16'h7800,
		16'h77ff, 16'h7808, 16'h7808, 16'h7807, 16'h7801, 16'h77fc,
		16'h7803, 16'h7801, 16'h77fb, 16'h7805, 16'h7801, 16'h77fd};

	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        init_n_i = 1'b1;
	logic        halt_button_i = 1'b0;
	logic        user_debug_n_i = 1'b1;
	logic        step_mode_i = 1'b0;
	logic        hsel = 1'b1;
	logic [3:0]  avs_address_i = 4'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        as_n, br, hf, drv_o, dae_o, halt_o, mon_n_o;
	logic [15:0] cpu_a, addr_o;
	int          errors = 0;
	int          n_checks = 0;
	rdms_note_s  notes [$];
	rdms_note_s  nt;

	always #20 clk_i = ~clk_i;

	rdms_cpu_model cpu (.clk_i, .address_strobe_n_o(as_n),
		.processor_bus_request_o(br), .halt_flag_bit_o(hf),
		.cpu_addr_o(cpu_a));

	rdms_top dut (.clk_i, .rst_n_i, .address_strobe_n_i(as_n),
		.processor_bus_request_i(br), .halt_flag_bit_i(hf), .init_n_i,
		.cpu_addr_i(cpu_a), .halt_button_i, .user_debug_n_i, .step_mode_i,
		.halt_instruction_selector_i(hsel), .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i,
		.avs_readdata_o, .avs_waitrequest_o, .addr_o,
		.cpu_addr_drive_enable_o(drv_o), .debug_addr_enable_o(dae_o),
		.halt_request_o(halt_o), .monitor_active_n_o(mon_n_o));

	// ==========================================================
	// checking
	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// notes are taken at the falling edge, where outputs have settled
	always @(negedge clk_i) begin
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			case (nt.sel)
				0: check("addr", addr_o, nt.v);
				1: check("halt", {15'h0000, halt_o}, nt.v);
				2: check("seq_en", {15'h0000, dae_o}, nt.v);
				3: check("mon_n", {15'h0000, mon_n_o}, nt.v);
				4: check("cpu_drv", {15'h0000, drv_o}, nt.v);
				default: check("rdata", avs_readdata_o[15:0], nt.v);
			endcase
		end
	end

	task automatic tally_and_finish();
		@(negedge clk_i);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		errors++;
		tally_and_finish();
	end

	// ==========================================================
	// drivers
	task automatic expect_v(input int sel, input logic [15:0] v);
		notes.push_back('{sel, v});
	endtask

	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= ~w;
		avs_writedata_i <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 50);
		if (k >= 50) begin
			errors++;
			tally_and_finish();
		end
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic req(input logic [15:0] a, e);
		cpu.req_hi(a);
		repeat (6 + $urandom_range(3)) @(posedge clk_i);
		expect_v(0, e);
		@(posedge clk_i);
		cpu.req_lo();
		repeat (8) @(posedge clk_i);
	endtask

	task automatic source(input int src, input logic on);
		case (src)
			0: halt_button_i <= on;
			1: user_debug_n_i <= ~on;
			2: av(1'b1, REG_CONTROL, {31'h0000_0000, on});
			3: step_mode_i <= on;
			default: ;
		endcase
	endtask

	task automatic run_seq(input int base, n, src);
		for (int i = 0; i < n; i++) begin
			req(16'($urandom), SEQ[base + i]);
			if (i == 0 && src < 3)
				source(src, 1'b0);
		end
	endtask

	task automatic round(input int src);
		logic [15:0] a;
		run_seq(0, 20, src);
		expect_v(2, 16'h0000);
		expect_v(4, 16'h0001);
		cpu.strobe(1'b0);
		expect_v(1, 16'h0000);
		cpu.strobe(1'b1);
		expect_v(1, 16'h0001);
		run_seq(20, 10, -1);
		expect_v(1, 16'h0000);
		expect_v(3, 16'h0001);
		expect_v(2, 16'h0000);
		a = 16'($urandom);
		req(a, a);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(74593));
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		expect_v(1, 16'h0001);
		expect_v(2, 16'h0001);
		expect_v(3, 16'h0000);
		expect_v(0, 16'h0000);
		av(1'b0, REG_STATUS, 32'h0000_0000);
		expect_v(5, 16'h0019);
		av(1'b0, 4'h8, 32'h0000_0000);
		expect_v(5, 16'h0000);
		avs_byteenable_i <= 4'he;
		av(1'b1, REG_CONTROL, 32'h0000_0001);
		avs_byteenable_i <= 4'hf;
		av(1'b0, REG_CONTROL, 32'h0000_0000);
		expect_v(5, 16'h0000);
		run_seq(0, 5, -1);
		init_n_i <= 1'b0;
		@(posedge clk_i);
		init_n_i <= 1'b1;
		@(posedge clk_i);
		expect_v(2, 16'h0001);
		expect_v(3, 16'h0000);
		expect_v(4, 16'h0000);
		round(-1);
		hsel <= 1'b0;
		cpu.strobe(1'b1);
		expect_v(1, 16'h0000);
		hsel <= 1'b1;
		cpu.strobe(1'b1);
		expect_v(1, 16'h0001);
		for (int s = 0; s < 4; s++) begin
			source(s, 1'b1);
			cpu.strobe(1'b0);
			expect_v(1, 16'h0001);
			round(s);
		end
		cpu.strobe(1'b0);
		expect_v(1, 16'h0001);
		tally_and_finish();
	end
endmodule // testbench
